// file: cache_policy_pkg.sv
// Package: register map, field positions, reset values and types for the cache policy controller
//
// Overview of operation
// - Both global flags set: read hits served, misses no allocate, no coherency.
// - Both-set mode: write hit updates line; exclusive line becomes modified.
// - Both-set mode: shared line stays shared after write hit.
// - Both-set mode: write miss goes straight to memory, no line fill.
// - Both-set mode: snoop hits never invalidate; explicit invalidate ops still do.
// - Both-set mode: first level ignores snoops; second and third levels snoop.
// - Older variant resets into the both-flags-set mode.
// - Newer variant: both set means no-fill; write policy ignored when disabled.
// - Low-power variant: cache-disable set turns caching fully off.
// - Write policy at bit 29; both clear gives write-back unless the page flag or the pin selects write-through.
// - Oldest variant, L1 disabled: accept snoops if dual-processor, else inhibit.
// - Snoops inhibited: no parity check, error output low; else check it.
// - Page cache-disable acts only with paging on and global disable clear.
// - Page write-through acts only with paging on and global policy clear.
// - Directory base flags govern only the page directory, same conditions.
// - Global entry bit keeps translation on flush only when enable bit set.
// - Misc enables bit 6 disables only the third-level cache.
// - Page disable and write-through outputs follow the active page flags.
// - Region types by address range; attribute table register is only stored and read back.
// - Disable clear with write policy set faults with error code zero.
package cache_policy_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_ZERO_OFS = 8'h00;
   localparam logic [7:0] DIR_BASE_OFS = 8'h04;
   localparam logic [7:0] CTRL_FOUR_OFS = 8'h08;
   localparam logic [7:0] MISC_EN_OFS = 8'h0C;
   localparam logic [7:0] REGION_BASE_OFS = 8'h10;
   localparam logic [7:0] PAT_OFS = 8'h30;
   localparam logic [7:0] STATUS_OFS = 8'h34;
   localparam logic [7:0] FAULT_OFS = 8'h38;
   localparam logic [7:0] VARIANT_OFS = 8'h3C;

   // Field positions
   localparam int CR0_PAGING_BIT = 31;
   localparam int CR0_CD_BIT = 30;
   localparam int CR0_NW_BIT = 29;
   localparam int DIR_PWT_BIT = 3;
   localparam int DIR_PCD_BIT = 4;
   localparam int CR4_PGE_BIT = 7;
   localparam int MISC_L3_DIS_BIT = 6;

   // Reset values
   localparam logic [31:0] CR0_RESET_OLD = 32'h6000_0000;
   localparam logic [31:0] CR0_RESET_NEW = 32'h4000_0000;
   localparam logic [1:0] VARIANT_RESET = 2'h0;
   localparam int REGION_COUNT = 4;
   localparam logic [7:0] PROT_FAULT_CODE = 8'h00;

   // Memory types
   localparam logic [2:0] MT_UC = 3'h0;
   localparam logic [2:0] MT_WC = 3'h1;
   localparam logic [2:0] MT_WT = 3'h4;
   localparam logic [2:0] MT_WP = 3'h5;
   localparam logic [2:0] MT_WB = 3'h6;

   typedef enum logic [1:0] {VAR_OLDEST, VAR_OLDER, VAR_NEWER, VAR_LOWPOWER} variant_t;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_NOFILL, MODE_NOCOHERE, MODE_OFF} cache_mode_t;
   typedef enum logic [1:0] {LINE_INVALID, LINE_SHARED, LINE_EXCLUSIVE, LINE_MODIFIED} line_state_t;

   // One access from the core
   typedef struct packed {
      logic valid;
      logic write;
      logic hit;
      logic isDirectory;
      logic pageCd;
      logic pageWt;
      logic [1:0] lineState;
      logic [31:0] addr;
   } access_t;

   // Decision for one access
   typedef struct packed {
      logic cacheable;
      logic writeThrough;
      logic allocate;
      logic updateLine;
      logic toMemory;
      logic [1:0] newState;
      logic [2:0] memType;
   } decision_t;

endpackage : cache_policy_pkg

// file: cache_mode_policy_control.sv
// Cache mode and page policy controller with AHB-Lite register access
`timescale 1ns/10ps
module cache_mode_policy_control (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Core access request
   input wire cache_policy_pkg::access_t coreAccess,
   output cache_policy_pkg::decision_t decision,
   // Explicit cache maintenance
   input wire logic invalidateDiscardOp,
   input wire logic writebackInvalidateOp,
   output logic invalidateAll,
   // TLB flush
   input wire logic tlbFlush,
   input wire logic entryGlobal,
   output logic keepTranslation,
   // Snoop port from the system bus
   input wire logic snoopValid,
   input wire logic snoopHit,
   input wire logic [31:0] snoopAddr,
   input wire logic snoopAddrParity,
   input wire logic dualProcessor,
   output logic snoopL1Accept,
   output logic snoopL23Accept,
   output logic snoopInvalidate,
   output logic address_parity_error_out,
   // External per-access policy pins
   input wire logic cache_enable_input_b,
   input wire logic write_policy_input,
   // External cache policy pins
   output logic pageCacheDisablePin,
   output logic pageWriteThroughPin,
   output logic l3Enable,
   // Fault report
   output logic protectionFault
);

   // Reset release
   logic rstMeta_ff;
   logic rstSync_ff;
   logic rstN;

   // Pin synchronisers
   logic kenMeta_ff;
   logic kenSync_ff;
   logic wbMeta_ff;
   logic wbSync_ff;
   logic dpMeta_ff;
   logic dpSync_ff;

   // Registers
   logic [31:0] ctrlZero_ff;
   logic [31:0] dirBase_ff;
   logic [31:0] ctrlFour_ff;
   logic [31:0] miscEn_ff;
   logic [31:0] regionTypes_ff [cache_policy_pkg::REGION_COUNT];
   logic [31:0] patReg_ff;
   logic [1:0] variant_ff;
   logic faultSticky_ff;

   // AHB data phase
   logic dataPhase_ff;
   logic dataWrite_ff;
   logic [7:0] dataAddr_ff;

   // Decoded flags
   logic cd;
   logic nw;
   logic paging;
   cache_policy_pkg::cache_mode_t mode;

   // Async assert, synchronous release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end
   assign rstN = rstSync_ff;

   // Two-stage synchronisers for outside pins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         kenMeta_ff <= 1'b1;
         kenSync_ff <= 1'b1;
         wbMeta_ff <= 1'b0;
         wbSync_ff <= 1'b0;
         dpMeta_ff <= 1'b0;
         dpSync_ff <= 1'b0;
      end else begin
         kenMeta_ff <= cache_enable_input_b;
         kenSync_ff <= kenMeta_ff;
         wbMeta_ff <= write_policy_input;
         wbSync_ff <= wbMeta_ff;
         dpMeta_ff <= dualProcessor;
         dpSync_ff <= dpMeta_ff;
      end
   end

   // Mode decode from the flags held right now
   function automatic cache_policy_pkg::cache_mode_t decodeMode(
      input logic cdIn, input logic nwIn, input logic [1:0] varIn);
      cache_policy_pkg::cache_mode_t m;

      m = cache_policy_pkg::MODE_NORMAL;
      if (cdIn) begin
         if (varIn == cache_policy_pkg::VAR_LOWPOWER) begin
            m = cache_policy_pkg::MODE_OFF;
         end else if (varIn == cache_policy_pkg::VAR_NEWER) begin
            m = cache_policy_pkg::MODE_NOFILL;
         end else if (nwIn) begin
            m = cache_policy_pkg::MODE_NOCOHERE;
         end else begin
            m = cache_policy_pkg::MODE_NOFILL;
         end
      end
      return m;
   endfunction : decodeMode

   // Byte address to region slot
   function automatic logic [1:0] regionOf(input logic [31:0] a);
      return a[31:30];
   endfunction : regionOf

   assign cd = ctrlZero_ff[cache_policy_pkg::CR0_CD_BIT];
   assign nw = ctrlZero_ff[cache_policy_pkg::CR0_NW_BIT];
   assign paging = ctrlZero_ff[cache_policy_pkg::CR0_PAGING_BIT];

   assign mode = decodeMode(cd, nw, variant_ff);

   // Bus slave: zero wait states, always OKAY
   logic addrPhase;
   logic writeBad;

   assign addrPhase = hsel && hready && htrans[1];
   assign writeBad = hwdata[cache_policy_pkg::CR0_NW_BIT]
      && !hwdata[cache_policy_pkg::CR0_CD_BIT];

   // Reads fetch in the address phase; writes land in the data phase
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         dataPhase_ff <= 1'b0;
         dataWrite_ff <= 1'b0;
         dataAddr_ff <= 8'h00;
      end else begin
         dataPhase_ff <= addrPhase;
         dataWrite_ff <= addrPhase && hwrite;
         dataAddr_ff <= haddr[7:0];
      end
   end

   // Register writes; the bad flag pair is refused, leaving the old value
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrlZero_ff <= cache_policy_pkg::CR0_RESET_OLD;
         dirBase_ff <= 32'h0000_0000;
         ctrlFour_ff <= 32'h0000_0000;
         miscEn_ff <= 32'h0000_0000;
         patReg_ff <= 32'h0000_0000;
         variant_ff <= cache_policy_pkg::VARIANT_RESET;
         for (int i = 0; i < cache_policy_pkg::REGION_COUNT; i++) begin
            regionTypes_ff[i] <= 32'h0000_0000;
         end
      end else if (dataWrite_ff) begin
         if (dataAddr_ff == cache_policy_pkg::CTRL_ZERO_OFS) begin
            if (!writeBad) begin
               ctrlZero_ff <= hwdata;
            end
         end else if (dataAddr_ff == cache_policy_pkg::DIR_BASE_OFS) begin
            dirBase_ff <= hwdata;
         end else if (dataAddr_ff == cache_policy_pkg::CTRL_FOUR_OFS) begin
            ctrlFour_ff <= hwdata;
         end else if (dataAddr_ff == cache_policy_pkg::MISC_EN_OFS) begin
            miscEn_ff <= hwdata;
         end else if (dataAddr_ff == cache_policy_pkg::PAT_OFS) begin
            patReg_ff <= hwdata;
         end else if (dataAddr_ff == cache_policy_pkg::VARIANT_OFS) begin
            variant_ff <= hwdata[1:0];
            // Newer cores come out of reset in no-fill; software picks the variant
            if (hwdata[1]) begin
               ctrlZero_ff[cache_policy_pkg::CR0_NW_BIT] <= 1'b0;
            end
         end else if (dataAddr_ff >= cache_policy_pkg::REGION_BASE_OFS
            && dataAddr_ff < cache_policy_pkg::PAT_OFS) begin
            regionTypes_ff[dataAddr_ff[3:2]] <= hwdata;
         end
      end
   end

   // Fault pulse and sticky status; a new fault wins over a clear
   logic clrFault;
   assign clrFault = dataWrite_ff
      && dataAddr_ff == cache_policy_pkg::FAULT_OFS;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         protectionFault <= 1'b0;
         faultSticky_ff <= 1'b0;
      end else begin
         protectionFault <= dataWrite_ff && writeBad
            && dataAddr_ff == cache_policy_pkg::CTRL_ZERO_OFS;

         if (dataWrite_ff && writeBad
            && dataAddr_ff == cache_policy_pkg::CTRL_ZERO_OFS) begin
            faultSticky_ff <= 1'b1;
         end else if (clrFault) begin
            faultSticky_ff <= 1'b0;
         end
      end
   end

   // Read mux, registered so the data sits in the data phase
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (haddr[7:0] == cache_policy_pkg::CTRL_ZERO_OFS) begin
         nxt_rdata = ctrlZero_ff;
      end else if (haddr[7:0] == cache_policy_pkg::DIR_BASE_OFS) begin
         nxt_rdata = dirBase_ff;
      end else if (haddr[7:0] == cache_policy_pkg::CTRL_FOUR_OFS) begin
         nxt_rdata = ctrlFour_ff;
      end else if (haddr[7:0] == cache_policy_pkg::MISC_EN_OFS) begin
         nxt_rdata = miscEn_ff;
      end else if (haddr[7:0] == cache_policy_pkg::PAT_OFS) begin
         nxt_rdata = patReg_ff;
      end else if (haddr[7:0] == cache_policy_pkg::STATUS_OFS) begin
         nxt_rdata = {28'h0, 2'(mode), l3Enable, snoopL1Accept};
      end else if (haddr[7:0] == cache_policy_pkg::FAULT_OFS) begin
         nxt_rdata = {23'h0, faultSticky_ff, cache_policy_pkg::PROT_FAULT_CODE};
      end else if (haddr[7:0] == cache_policy_pkg::VARIANT_OFS) begin
         nxt_rdata = {30'h0, variant_ff};
      end else if (haddr[7:0] >= cache_policy_pkg::REGION_BASE_OFS
         && haddr[7:0] < cache_policy_pkg::PAT_OFS) begin
         nxt_rdata = regionTypes_ff[haddr[3:2]];
      end
   end

   // Bus response registers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= (addrPhase && !hwrite) ? nxt_rdata
            : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Per-access decision
   cache_policy_pkg::decision_t nxt_decision;
   logic effCd;
   logic effWt;
   logic pageCdAct;
   logic pageWtAct;
   logic [2:0] regionType;

   always_comb begin
      regionType = regionTypes_ff[regionOf(coreAccess.addr)][2:0];

      // Directory accesses take the base register flags, pages their own
      pageCdAct = coreAccess.isDirectory ? dirBase_ff[cache_policy_pkg::DIR_PCD_BIT]
         : coreAccess.pageCd;
      pageWtAct = coreAccess.isDirectory ? dirBase_ff[cache_policy_pkg::DIR_PWT_BIT]
         : coreAccess.pageWt;

      effCd = paging && !cd && pageCdAct;
      effWt = paging && !nw && pageWtAct;

      nxt_decision = '0;
      nxt_decision.memType = effCd ? cache_policy_pkg::MT_UC
         : (effWt && regionType == cache_policy_pkg::MT_WB) ? cache_policy_pkg::MT_WT
         : regionType;
      nxt_decision.cacheable = !effCd && !kenSync_ff
         && nxt_decision.memType != cache_policy_pkg::MT_UC
         && mode != cache_policy_pkg::MODE_OFF;
      nxt_decision.writeThrough = effWt || !wbSync_ff;
      nxt_decision.newState = coreAccess.lineState;

      if (coreAccess.valid && nxt_decision.cacheable) begin
         if (!coreAccess.write) begin
            nxt_decision.allocate = !coreAccess.hit
               && mode == cache_policy_pkg::MODE_NORMAL;
         end else if (coreAccess.hit) begin
            nxt_decision.updateLine = 1'b1;
            if (coreAccess.lineState == cache_policy_pkg::LINE_EXCLUSIVE) begin
               nxt_decision.newState = cache_policy_pkg::LINE_MODIFIED;
            end
            // Shared lines stay shared and write through to memory
            nxt_decision.toMemory = coreAccess.lineState == cache_policy_pkg::LINE_SHARED
               || nxt_decision.writeThrough;
         end else begin
            nxt_decision.toMemory = 1'b1;
            nxt_decision.allocate = mode == cache_policy_pkg::MODE_NORMAL;
         end
      end else if (coreAccess.valid && coreAccess.write) begin
         nxt_decision.toMemory = 1'b1;
      end
   end

   // Registered decision and pins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         decision <= '0;
         pageCacheDisablePin <= 1'b0;
         pageWriteThroughPin <= 1'b0;
      end else begin
         decision <= nxt_decision;
         pageCacheDisablePin <= effCd;
         pageWriteThroughPin <= effWt;
      end
   end

   // Snoop handling and address parity
   logic l1Disabled;
   logic snoopOn;
   assign l1Disabled = mode == cache_policy_pkg::MODE_NOCOHERE;

   // Oldest core keeps L1 snooping in dual-processor systems only
   assign snoopOn = !l1Disabled
      || (variant_ff == cache_policy_pkg::VAR_OLDEST && dpSync_ff);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         snoopL1Accept <= 1'b1;
         snoopL23Accept <= 1'b1;
         snoopInvalidate <= 1'b0;
         address_parity_error_out <= 1'b0;
      end else begin
         snoopL1Accept <= snoopOn;
         snoopL23Accept <= 1'b1;
         snoopInvalidate <= snoopValid && snoopHit && !l1Disabled;
         address_parity_error_out <= snoopValid && snoopOn
            && (^snoopAddr != snoopAddrParity);
      end
   end

   // Explicit invalidation always acts, TLB retention, third-level enable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         invalidateAll <= 1'b0;
         keepTranslation <= 1'b0;
         l3Enable <= 1'b1;
      end else begin
         invalidateAll <= invalidateDiscardOp
            || writebackInvalidateOp;
         keepTranslation <= tlbFlush && entryGlobal
            && ctrlFour_ff[cache_policy_pkg::CR4_PGE_BIT];
         l3Enable <= !miscEn_ff[cache_policy_pkg::MISC_L3_DIS_BIT]
            && mode != cache_policy_pkg::MODE_OFF;
      end
   end

endmodule : cache_mode_policy_control

// file: cache_mode_policy_control_props.sv
// Port-level assertion checker for the cache policy controller
`timescale 1ns/10ps
module cache_mode_policy_control_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Access path
   input wire cache_policy_pkg::decision_t decision,
   input wire logic cache_enable_input_b,
   // Maintenance and translation
   input wire logic invalidateDiscardOp,
   input wire logic writebackInvalidateOp,
   input wire logic invalidateAll,
   input wire logic tlbFlush,
   input wire logic entryGlobal,
   input wire logic keepTranslation,
   // Snoop side
   input wire logic snoopValid,
   input wire logic snoopHit,
   input wire logic [31:0] snoopAddr,
   input wire logic snoopAddrParity,
   input wire logic snoopL23Accept,
   input wire logic snoopInvalidate,
   input wire logic address_parity_error_out,
   input wire logic protectionFault
);
   logic [1:0] upCnt_ff;
   logic live;

   // Internal reset lags the pin by two edges, so requests before then are not judged
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         upCnt_ff <= 2'h0;
      else if (upCnt_ff != 2'h3)
         upCnt_ff <= upCnt_ff + 2'h1;
   end
   assign live = (upCnt_ff == 2'h3);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Maintenance request and the flush it must cause
   sequence s_maint_req;
      live && (invalidateDiscardOp || writebackInvalidateOp);
   endsequence
   sequence s_flush_all;
      invalidateAll;
   endsequence

   a_maint_invalidates: assert property (s_maint_req |=> s_flush_all)
      else $error("Maintenance request did not invalidate");
   a_maint_cause: assert property (invalidateAll |-> $past(invalidateDiscardOp) || $past(writebackInvalidateOp))
      else $error("Invalidate without a maintenance request");
   a_keep_cause: assert property (keepTranslation |-> $past(tlbFlush) && $past(entryGlobal))
      else $error("Translation kept without a global flush");
   a_snoop_inval: assert property (snoopInvalidate |-> $past(snoopValid) && $past(snoopHit))
      else $error("Snoop invalidate without a snoop hit");
   a_parity_cause: assert property (address_parity_error_out |-> $past(snoopValid) && ((^$past(snoopAddr)) != $past(snoopAddrParity)))
      else $error("Parity error without a corrupt snoop address");
   a_l23_snoop: assert property (snoopL23Accept)
      else $error("Outer cache levels stopped snooping");
   a_fault_single: assert property (protectionFault |=> !protectionFault)
      else $error("Protection fault longer than one cycle");
   a_cache_pin: assert property (decision.cacheable |-> !$past(cache_enable_input_b, 3))
      else $error("Cacheable while outside hardware forbids it");
endmodule : cache_mode_policy_control_props

bind cache_mode_policy_control cache_mode_policy_control_props u_props (.clk, .rst_b, .decision,
   .cache_enable_input_b, .invalidateDiscardOp, .writebackInvalidateOp, .invalidateAll, .tlbFlush,
   .entryGlobal, .keepTranslation, .snoopValid, .snoopHit, .snoopAddr, .snoopAddrParity,
   .snoopL23Accept, .snoopInvalidate, .address_parity_error_out, .protectionFault);

// file: snoop_bus_model.sv
// System bus model: snooping agent and external cache policy pins
`timescale 1ns/10ps
module snoop_bus_model (
   // Clock and commands
   input wire logic clk,
   input wire logic doSnoop,
   input wire logic badParity,
   input wire logic [31:0] reqAddr,
   input wire logic kenOff,
   // Pins towards the device
   output logic snoopValid,
   output logic snoopHit,
   output logic [31:0] snoopAddr,
   output logic snoopAddrParity,
   output logic cache_enable_input_b,
   output logic write_policy_input
);
   initial begin
      snoopValid = 1'b0;
      snoopHit = 1'b0;
      snoopAddr = 32'h0;
      snoopAddrParity = 1'b0;
      cache_enable_input_b = 1'b0;
      write_policy_input = 1'b1;
   end

   // Idle cycles show inverted address lines so a stale value never looks like a request
   always @(posedge clk) begin
      snoopValid <= doSnoop;
      snoopHit <= doSnoop;
      snoopAddr <= doSnoop ? reqAddr : ~snoopAddr;
      snoopAddrParity <= doSnoop ? ((^reqAddr) ^ badParity) : ~snoopAddrParity;
      cache_enable_input_b <= kenOff;
      write_policy_input <= 1'b1;
   end
endmodule : snoop_bus_model

// file: cache_mode_policy_control_tb.sv
// Self-checking bench of the cache policy controller
`timescale 1ns/10ps
module cache_mode_policy_control_tb;
   logic clk, rst_b, hsel, hwrite, hresp, hreadyout, invOp, wbInvOp, invalidateAll;
   logic [31:0] haddr, hwdata, hrdata, snoopAddr, reqAddr, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   cache_policy_pkg::access_t coreAccess;
   cache_policy_pkg::decision_t decision;
   logic tlbFlush, entryGlobal, keepTranslation, snoopValid, snoopHit, snoopAddrParity;
   logic dualProcessor, snoopL1Accept, snoopL23Accept, snoopInvalidate, parErr;
   logic kenB, wbPin, cdPin, wtPin, l3Enable, protectionFault, doSnoop, badParity, kenOff;
   logic faultSeen = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   int seed;
   int r;

   cache_mode_policy_control u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .coreAccess(coreAccess),
      .decision(decision), .invalidateDiscardOp(invOp), .writebackInvalidateOp(wbInvOp),
      .invalidateAll(invalidateAll), .tlbFlush(tlbFlush), .entryGlobal(entryGlobal),
      .keepTranslation(keepTranslation), .snoopValid(snoopValid), .snoopHit(snoopHit),
      .snoopAddr(snoopAddr), .snoopAddrParity(snoopAddrParity), .dualProcessor(dualProcessor),
      .snoopL1Accept(snoopL1Accept), .snoopL23Accept(snoopL23Accept),
      .snoopInvalidate(snoopInvalidate), .address_parity_error_out(parErr),
      .cache_enable_input_b(kenB), .write_policy_input(wbPin), .pageCacheDisablePin(cdPin),
      .pageWriteThroughPin(wtPin), .l3Enable(l3Enable), .protectionFault(protectionFault));

   snoop_bus_model u_bus (.clk(clk), .doSnoop(doSnoop), .badParity(badParity), .reqAddr(reqAddr),
      .kenOff(kenOff), .snoopValid(snoopValid), .snoopHit(snoopHit), .snoopAddr(snoopAddr),
      .snoopAddrParity(snoopAddrParity), .cache_enable_input_b(kenB), .write_policy_input(wbPin));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Fault is a one-cycle pulse, so latch it rather than sample it late
   always @(posedge clk) if (protectionFault === 1'b1) faultSeen <= 1'b1;

   task automatic results;
      $display("Compared %0d values, %0d mismatches", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One AHB-Lite single word transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
      chk({hresp, hreadyout}, 2'h1);
   endtask : rdc

   // Core access in region zero; decision is looked at one cycle later
   task automatic acc(input logic w, h, cd, wt, dir, input logic [1:0] ls);
      logic [31:0] ad;
      ad = $random(seed) & 32'h3FFF_FFFF;
      @(posedge clk);
      coreAccess <= '{1'b1, w, h, dir, cd, wt, ls, ad};
      @(posedge clk);
      coreAccess.valid <= 1'b0;
      #1;
   endtask : acc

   task automatic snoop(input logic bad);
      @(posedge clk);
      doSnoop <= 1'b1;
      badParity <= bad;
      reqAddr <= $random(seed);
      @(posedge clk);
      doSnoop <= 1'b0;
      @(posedge clk);
      #1;
   endtask : snoop

   task automatic pulse(input int which);
      @(posedge clk);
      invOp <= (which == 0);
      wbInvOp <= (which == 1);
      tlbFlush <= (which == 2);
      entryGlobal <= (which == 2);
      @(posedge clk);
      {invOp, wbInvOp, tlbFlush, entryGlobal} <= 4'h0;
      #1;
   endtask : pulse

   // Bounded run: everything finishes well inside this span
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      results();
   end

   initial begin
      seed = 83358;
      {rst_b, hsel, hwrite, invOp, wbInvOp, tlbFlush, entryGlobal} = 7'h0;
      {dualProcessor, doSnoop, badParity, kenOff} = 4'h0;
      {haddr, hwdata, reqAddr} = {32'h0, 32'h0, 32'h0};
      htrans = 2'h0;
      hsize = 3'h2;
      coreAccess = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(8'h00, 32'hFFFF_FFFF, 32'h6000_0000);
      rdc(8'h34, 32'h0000_000F, 32'h0000_000A);
      rdc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
      bus(1'b1, 8'h10, {29'h0, cache_policy_pkg::MT_WB});
      for (int i = 0; i < 10; i++) begin
         r = (i == 0) ? 7 : (i == 1) ? 3 : (i == 2) ? 1 : $random(seed);
         acc(r[0], r[1], 1'b0, 1'b0, 1'b0, r[2] ? cache_policy_pkg::LINE_EXCLUSIVE
            : cache_policy_pkg::LINE_SHARED);
         chk(decision.allocate, 1'b0);
         if (r[0] && r[1]) chk(decision.updateLine, 1'b1);
         if (r[0] && r[1]) chk(decision.newState, r[2] ? 2'h3 : 2'h1);
         if (r[0] && !r[1]) chk(decision.toMemory, 1'b1);
      end
      snoop(1'b1);
      chk({snoopInvalidate, parErr}, 2'h0);
      for (int k = 0; k < 2; k++) begin
         pulse(k);
         chk(invalidateAll, 1'b1);
      end
      dualProcessor <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(8'h34, 32'h0000_000F, 32'h0000_000B);
      snoop(1'b1);
      chk(parErr, 1'b1);
      snoop(1'b0);
      chk(parErr, 1'b0);
      bus(1'b1, 8'h00, 32'h2000_0000);
      rdc(8'h00, 32'hFFFF_FFFF, 32'h6000_0000);
      rdc(8'h38, 32'h0000_01FF, 32'h0000_0100);
      chk(faultSeen, 1'b1);
      bus(1'b1, 8'h00, 32'h0000_0000);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2);
      chk(decision.cacheable, 1'b1);
      bus(1'b1, 8'h00, 32'h8000_0000);
      rdc(8'h34, 32'h0000_000C, 32'h0000_0000);
      snoop(1'b0);
      chk(snoopInvalidate, 1'b1);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2);
      chk({decision.cacheable, cdPin}, 2'h1);
      acc(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h2);
      chk({decision.cacheable, decision.writeThrough, wtPin}, 3'h7);
      chk(decision.memType, cache_policy_pkg::MT_WT);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
      chk({decision.cacheable, decision.writeThrough}, 2'h2);
      kenOff <= 1'b1;
      repeat (4) @(posedge clk);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
      chk(decision.cacheable, 1'b0);
      kenOff <= 1'b0;
      bus(1'b1, 8'h04, 32'h0000_0010);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2);
      chk(decision.cacheable, 1'b0);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
      chk(decision.cacheable, 1'b1);
      for (int g = 0; g < 2; g++) begin
         bus(1'b1, 8'h08, g ? 32'h0000_0080 : 32'h0);
         pulse(2);
         chk(keepTranslation, g[0]);
      end
      for (int l = 0; l < 2; l++) begin
         bus(1'b1, 8'h0C, l ? 32'h0 : 32'h0000_0040);
         rdc(8'h34, 32'h0000_000E, l ? 32'h2 : 32'h0);
         chk(l3Enable, l[0]);
      end
      bus(1'b1, 8'h00, 32'h6000_0000);
      bus(1'b1, 8'h3C, 32'h0000_0002);
      rdc(8'h00, 32'hFFFF_FFFF, 32'h4000_0000);
      bus(1'b1, 8'h00, 32'h6000_0000);
      rdc(8'h34, 32'h0000_000C, 32'h0000_0004);
      bus(1'b1, 8'h3C, 32'h0000_0003);
      bus(1'b1, 8'h00, 32'h6000_0000);
      rdc(8'h34, 32'h0000_000C, 32'h0000_000C);
      results();
   end
endmodule : cache_mode_policy_control_tb
